// ---- pmh_host.sv ----
// pmh_host: remote requester, sends command frames and takes reply bytes
// assumes: same clock as the handler; slow makes the reply sink stall
`timescale 1ns/1ns
module pmh_host (
	input wire logic i_core_clk,
	output logic o_rx_valid,
	output logic [7:0] o_rx_byte,
	output logic o_rx_last,
	input wire logic i_rx_ready,
	output logic o_tx_ready,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_byte,
	input wire logic i_tx_last
);
	logic [7:0] reply[$];
	logic done = 1'b0;
	logic slow = 1'b0;
	int hang = 0;
	initial begin
		o_rx_valid = 1'b0;
		o_rx_byte = 8'h00;
		o_rx_last = 1'b0;
		o_tx_ready = 1'b0;
	end
	always @(posedge i_core_clk) begin
		o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
		if (i_tx_valid && o_tx_ready) begin
			reply.push_back(i_tx_byte);
			if (i_tx_last) done <= 1'b1;
		end
	end
	// request held until the edge that takes it
	task automatic send(input logic [7:0] f[$]);
		int n;
		@(posedge i_core_clk);
		done <= 1'b0;
		reply.delete();
		foreach (f[i]) begin
			o_rx_valid <= 1'b1;
			o_rx_byte <= f[i];
			o_rx_last <= (i == f.size() - 1);
			n = 0;
			do begin
				@(posedge i_core_clk);
				n++;
			end while (!i_rx_ready && n < 200);
			if (n >= 200) hang++;
		end
		o_rx_valid <= 1'b0;
		o_rx_last <= 1'b0;
		// released line shows a changed value, never the stale byte
		o_rx_byte <= ~f[f.size() - 1];
	endtask
endmodule // pmh_host

// ---- pmh_pkg.sv ----
// pmh_pkg: constants, codes and types shared by the parameter/memory command handler
// assumes: one core clock, word-wide storage, byte-wide command and reply streams
package pmh_pkg;
	// ======================================================
	// command and end codes
	localparam logic [15:0] CMD_XFER = 16'h0105;
	localparam logic [15:0] CMD_PRD = 16'h0201;
	localparam logic [15:0] CMD_PWR = 16'h0202;
	localparam logic [15:0] EC_OK = 16'h0000;
	localparam logic [15:0] EC_CMD = 16'h0401;
	localparam logic [15:0] EC_LEN = 16'h1001;
	localparam logic [15:0] EC_AREA = 16'h1101;
	localparam logic [15:0] EC_RANGE = 16'h1103;
	localparam logic [15:0] EC_NOLAST = 16'h1104;
	localparam logic [15:0] EC_FMT = 16'h1105;
	localparam logic [15:0] EC_PROT = 16'h2101;
	localparam logic [15:0] EC_ACCESS = 16'h2102;
	localparam logic [15:0] EC_MODE = 16'h2201;
	// ======================================================
	// memory areas and parameter areas
	localparam logic [7:0] MA_CIO = 8'h80;
	localparam logic [7:0] MA_PV = 8'h81;
	localparam logic [7:0] MA_DM = 8'h82;
	localparam logic [7:0] MA_EM0 = 8'h90;
	localparam logic [7:0] MA_EMC = 8'h98;
	localparam logic [3:0] REGION_PV = 4'h1;
	localparam logic [3:0] REGION_EM0 = 4'h3;
	localparam int MEM_REGIONS = 11;
	localparam logic [15:0] PA_BASE = 16'h8010;
	localparam logic [2:0] PA_NUM = 3'h5;
	localparam logic [2:0] PA_IO = 3'h1;
	localparam logic [2:0] PA_RT = 3'h2;
	localparam logic [15:0] PA_WORDS = 16'h0200;
	localparam logic [15:0] RT_WORDS = 16'h0030;
	localparam logic [14:0] MAX_WORDS = 15'h010a;
	localparam int LAST_BIT = 15;
	localparam logic [3:0] HDR_XFER = 4'hc;
	localparam logic [3:0] HDR_PRM = 4'h8;
	localparam logic [2:0] MODE_PROG = 3'h0;
	// ======================================================
	// routing table format limits
	localparam logic [6:0] LNT_BYTES = 7'h22;
	localparam logic [7:0] LNT_MAX = 8'h10;
	localparam logic [7:0] UNIT_MIN = 8'h10;
	localparam logic [7:0] UNIT_MAX = 8'h1f;
	localparam logic [7:0] NET_MAX = 8'h7f;
	localparam logic [7:0] RNT_MAX = 8'h14;
	localparam logic [7:0] DST_MAX = 8'h7d;
	localparam logic [7:0] NODE_MAX = 8'h7e;
	// ======================================================
	// register port map and fields
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_RESTART = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_ADDR = 8'h0c;
	localparam logic [7:0] REG_DATA = 8'h10;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_KEY_BIT = 4;
	localparam int CTRL_FOREIGN_BIT = 5;
	localparam int CTRL_BANK_LSB = 8;
	localparam int ADDR_SPACE_LSB = 20;
	localparam int ADDR_REGION_LSB = 16;
	localparam logic [1:0] SP_MEM = 2'h0;
	localparam logic [1:0] SP_PRM = 2'h1;
	localparam logic [1:0] SP_RTACT = 2'h2;
	localparam logic [1:0] SP_FLAG = 2'h3;
	localparam logic [15:0] EC_RST = 16'h0000;

	typedef enum logic [5:0] {
		S_HDR = 6'h01,
		S_XFER = 6'h02,
		S_WDATA = 6'h04,
		S_DRAIN = 6'h08,
		S_RESP = 6'h10,
		S_LOAD = 6'h20
	} pmh_state_t;
endpackage

// ---- pmh_props.sv ----
// pmh_props: port checks for pmh_top
// assumes: bound into pmh_top from the tb file
`timescale 1ns/1ns
module pmh_props (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_byte,
	input wire logic i_rx_last,
	input wire logic o_rx_ready,
	input wire logic i_tx_ready,
	input wire logic o_tx_valid,
	input wire logic [7:0] o_tx_byte,
	input wire logic o_tx_last,
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [31:0] o_reg_rdata
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_resetn);
	// ==========
	// handshake sequences
	sequence s_cmd_end;
		i_rx_valid && o_rx_ready && i_rx_last;
	endsequence
	sequence s_reply_end;
		o_tx_valid && i_tx_ready && o_tx_last;
	endsequence
	// ==========
	// assertions
	a_tx_hold_stall: assert property (
		o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte) && $stable(o_tx_last))
		else $error("reply byte changed while stalled");
	a_busy_after_cmd: assert property (
		s_cmd_end |=> !o_rx_ready && !o_tx_valid)
		else $error("engine not busy after command end");
	a_reply_bounded: assert property (
		s_cmd_end |-> ##[2:600] o_tx_valid)
		else $error("no reply after command");
	a_no_rx_reply: assert property (
		o_tx_valid |-> !o_rx_ready)
		else $error("command taken during reply");
	a_ready_after_reply: assert property (
		s_reply_end |-> ##[1:8] o_rx_ready)
		else $error("not ready after reply");
	a_reply_ends: assert property (
		s_reply_end |=> !o_tx_valid)
		else $error("reply runs past last byte");
	a_rdata_idle: assert property (
		!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
		else $error("read data outside read slot");
	a_unmapped_zero: assert property (
		i_reg_rd && i_reg_addr == 8'h14 |=> o_reg_rdata == 32'h0)
		else $error("unmapped read not zero");
endmodule // pmh_props

// ---- pmh_ser.sv ----
// pmh_ser: splits reply words into bytes, upper byte first
// assumes: tx_ready comes from logic on the same clock
`timescale 1ns/1ns
module pmh_ser
	import pmh_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_resetn,
	pmh_ser_if.snk w,
	input wire logic i_tx_ready,
	output logic o_tx_valid,
	output logic [7:0] o_tx_byte,
	output logic o_tx_last
);
	typedef struct packed {
		logic vld;
		logic [7:0] byte_q;
		logic last;
		logic pend;
		logic [7:0] lo;
		logic lo_last;
	} pmh_ser_st_t;

	pmh_ser_st_t s_r;
	pmh_ser_st_t s_nxt;

	// lower byte held back so a word never accepted half-way
	assign w.ready = !s_r.pend && (!s_r.vld || i_tx_ready);

	always_comb begin
		s_nxt = s_r;
		if (s_r.vld && i_tx_ready) begin
			s_nxt.vld = 1'b0;
		end
		if (s_r.pend && (!s_r.vld || i_tx_ready)) begin
			s_nxt.vld = 1'b1;
			s_nxt.byte_q = s_r.lo;
			s_nxt.last = s_r.lo_last;
			s_nxt.pend = 1'b0;
		end else if (w.valid && w.ready) begin
			s_nxt.vld = 1'b1;
			s_nxt.byte_q = w.word[15:8];
			s_nxt.last = 1'b0;
			s_nxt.lo = w.word[7:0];
			s_nxt.lo_last = w.last;
			s_nxt.pend = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_tx_valid = s_r.vld;
	assign o_tx_byte = s_r.byte_q;
	assign o_tx_last = s_r.last;
endmodule // pmh_ser

// ---- pmh_ser_if.sv ----
// pmh_ser_if: reply words from the command engine to the byte serialiser
// assumes: both ends on the core clock
`timescale 1ns/1ns
interface pmh_ser_if;
	logic [15:0] word;
	logic last;
	logic valid;
	logic ready;
	modport src (output word, output last, output valid, input ready);
	modport snk (input word, input last, input valid, output ready);
endinterface

// ---- pmh_top.sv ----
// pmh_top: memory transfer, parameter read and parameter write command engine
// assumes: command bytes and reply bytes on the core clock; software on the register port
//
// How it works
// - transfer copies consecutive words, one area each
// - transfer runs in every operating mode
// - transfer into present values clears completion flags
// - codes 80, 81, 82 select two-byte word areas
// - codes 90-97 pick bank, 98 current bank
// - read asks at most 266 words
// - reply bit 15 marks area's final word
// - reply words go upper byte first
// - five parameter areas, each numbered from zero
// - routing reads limited to first 48 words
// - write carries at most 266 words
// - io table written only in program mode
// - foreign access right blocks parameter writes
// - key switch protection blocks parameter writes
// - write reaching last word needs bit 15
// - zero-word write writes nothing, answers normally
// - write data arrives upper byte first
// - routing written from word zero, format checked
// - new routing table active only after restart
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ns
module pmh_top
	import pmh_pkg::*;
#(
	parameter int MAW = 8,
	parameter int PAW = 9
) (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_byte,
	input wire logic i_rx_last,
	output logic o_rx_ready,
	input wire logic i_tx_ready,
	output logic o_tx_valid,
	output logic [7:0] o_tx_byte,
	output logic o_tx_last,
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata
);
	localparam int NT = 1 << MAW;
	localparam int MAI = 4 + MAW;
	localparam int PAI = 3 + PAW;
	localparam int MDEPTH = MEM_REGIONS << MAW;
	localparam int PDEPTH = 5 << PAW;

	typedef struct packed {
		pmh_state_t st;
		logic rx_rdy;
		logic [95:0] hdr;
		logic [3:0] hcnt;
		logic saw_last;
		logic [15:0] cmd;
		logic [15:0] ec;
		logic [15:0] last_ec;
		logic [3:0] src_r;
		logic [15:0] src_a;
		logic [3:0] dst_r;
		logic [15:0] dst_a;
		logic [14:0] cnt;
		logic [14:0] idx;
		logic [2:0] parea;
		logic [15:0] pcode;
		logic [15:0] pbeg;
		logic wr_ok;
		logic is_rt;
		logic lastf;
		logic [7:0] hi;
		logic have_hi;
		logic fmt_ok;
		logic [6:0] rb;
		logic [1:0] rj;
		logic [4:0] rk;
		logic [7:0] lcnt;
		logic [7:0] rcnt;
		logic [2:0] mode;
		logic key;
		logic foreign;
		logic [2:0] bank;
		logic [21:0] addr;
		logic rst_pend;
		logic stg_ok;
		logic act_ok;
		logic [31:0] rdata;
		logic [NT-1:0] cflag;
	} pmh_regs_t;

	pmh_regs_t s_r;
	pmh_regs_t s_nxt;
	pmh_ser_if ser ();

	// ======================================================
	// storage: memory areas, parameter areas, active routing table
	logic [15:0] mem_q [MDEPTH];
	logic [15:0] prm_q [PDEPTH];
	logic [15:0] rt_act [48];
	logic mem_we;
	logic [MAI-1:0] mem_wa;
	logic [15:0] mem_wd;
	logic prm_we;
	logic [PAI-1:0] prm_wa;
	logic [15:0] prm_wd;
	logic rt_we;
	logic [5:0] rt_wa;
	logic [15:0] rt_wd;

	always_ff @(posedge i_core_clk) begin
		if (mem_we) begin
			mem_q[mem_wa] <= mem_wd;
		end
		if (prm_we) begin
			prm_q[prm_wa] <= prm_wd;
		end
		if (rt_we) begin
			rt_act[rt_wa] <= rt_wd;
		end
	end

	// {valid, region}
	function automatic logic [4:0] map_area(input logic [7:0] c, input logic [2:0] bank);
		logic [4:0] r;
		r = 5'h00;
		if (c == MA_CIO || c == MA_PV || c == MA_DM) begin
			r = {1'b1, c[3:0]};
		end else if (c == MA_EMC) begin
			r = {1'b1, REGION_EM0 + {1'b0, bank}};
		end else if (c[7:3] == MA_EM0[7:3]) begin
			r = {1'b1, REGION_EM0 + {1'b0, c[2:0]}};
		end
		return r;
	endfunction

	// ======================================================
	// command engine
	logic take;
	logic [95:0] h;
	logic [4:0] sa;
	logic [4:0] da;
	logic [16:0] send;
	logic [16:0] dend;
	logic [16:0] pend;
	logic [15:0] psize;
	logic rng;
	logic [15:0] xs;
	logic [15:0] xd;
	logic [15:0] rlen;
	logic [15:0] roff;
	logic [7:0] v;
	logic bad;
	logic [6:0] eb;

	always_comb begin
		s_nxt = s_r;
		mem_we = 1'b0;
		mem_wa = '0;
		mem_wd = '0;
		prm_we = 1'b0;
		prm_wa = '0;
		prm_wd = '0;
		rt_we = 1'b0;
		rt_wa = '0;
		rt_wd = '0;
		ser.valid = 1'b0;
		ser.word = '0;
		ser.last = 1'b0;
		take = i_rx_valid && s_r.rx_rdy;
		v = i_rx_byte;
		h = {s_r.hdr[87:0], v};
		sa = map_area(h[79:72], s_r.bank);
		da = map_area(h[47:40], s_r.bank);
		send = {1'b0, h[71:56]} + {2'b00, h[14:0]};
		dend = {1'b0, h[39:24]} + {2'b00, h[14:0]};
		psize = (h[34:32] == PA_RT) ? RT_WORDS : PA_WORDS;
		pend = {1'b0, h[31:16]} + {2'b00, h[14:0]};
		rng = (h[31:16] < psize) && (pend <= {1'b0, psize}) && (h[14:0] <= MAX_WORDS);
		xs = s_r.src_a + {1'b0, s_r.idx};
		xd = s_r.dst_a + {1'b0, s_r.idx};
		rlen = (s_r.cmd == CMD_PRD && s_r.ec == EC_OK) ? 16'({1'b0, s_r.cnt} + 16'h0005) : 16'h0002;
		roff = s_r.pbeg + {1'b0, s_r.idx} - 16'h0005;
		bad = 1'b0;
		eb = s_r.rb - 7'h02;
		case (s_r.st)
			S_HDR: begin
				if (s_r.rst_pend && s_r.hcnt == 4'h0) begin
					s_nxt.st = S_LOAD;
					s_nxt.idx = '0;
				end else if (take) begin
					s_nxt.hdr = h;
					s_nxt.hcnt = s_r.hcnt + 4'h1;
					s_nxt.saw_last = i_rx_last;
					if (s_r.hcnt == 4'h1) begin
						s_nxt.cmd = h[15:0];
					end
					if (s_r.hcnt == 4'h1 && h[15:0] != CMD_XFER && h[15:0] != CMD_PRD
							&& h[15:0] != CMD_PWR) begin
						s_nxt.ec = EC_CMD;
						s_nxt.st = S_DRAIN;
					end else if (s_r.hcnt == HDR_XFER - 4'h1 && s_r.cmd == CMD_XFER) begin
						s_nxt.cnt = h[14:0];
						s_nxt.idx = '0;
						s_nxt.src_r = sa[3:0];
						s_nxt.src_a = h[71:56];
						s_nxt.dst_r = da[3:0];
						s_nxt.dst_a = h[39:24];
						s_nxt.st = S_DRAIN;
						if (!sa[4] || !da[4]) begin
							s_nxt.ec = EC_AREA;
						end else if (send > 17'(NT) || dend > 17'(NT) || h[15]) begin
							s_nxt.ec = EC_RANGE;
						end else if (h[14:0] != 15'h0000) begin
							s_nxt.st = S_XFER;
						end
					end else if (s_r.hcnt == HDR_PRM - 4'h1 && s_r.cmd != CMD_XFER) begin
						s_nxt.pcode = h[47:32];
						s_nxt.parea = h[34:32];
						s_nxt.pbeg = h[31:16];
						s_nxt.cnt = h[14:0];
						s_nxt.idx = '0;
						s_nxt.is_rt = (h[34:32] == PA_RT);
						s_nxt.lastf = (pend == {1'b0, psize});
						s_nxt.rb = '0;
						s_nxt.rj = '0;
						s_nxt.rk = '0;
						s_nxt.fmt_ok = 1'b1;
						s_nxt.have_hi = 1'b0;
						s_nxt.wr_ok = 1'b0;
						s_nxt.st = (s_r.cmd == CMD_PWR) ? S_WDATA : S_DRAIN;
						if (h[47:35] != PA_BASE[15:3] || h[34:32] >= PA_NUM) begin
							s_nxt.ec = EC_AREA;
						end else if (s_r.cmd == CMD_PRD) begin
							if (!rng || h[LAST_BIT]) begin
								s_nxt.ec = EC_RANGE;
							end
						end else if (h[14:0] == 15'h0000) begin
							s_nxt.ec = EC_OK;
						end else if (!rng) begin
							s_nxt.ec = EC_RANGE;
						end else if (s_r.foreign) begin
							s_nxt.ec = EC_ACCESS;
						end else if (s_r.key) begin
							s_nxt.ec = EC_PROT;
						end else if (h[34:32] == PA_IO && s_r.mode != MODE_PROG) begin
							s_nxt.ec = EC_MODE;
						end else if (h[34:32] == PA_RT && h[31:16] != 16'h0000) begin
							s_nxt.ec = EC_RANGE;
						end else if (pend == {1'b0, psize} && !h[LAST_BIT]) begin
							s_nxt.ec = EC_NOLAST;
						end else begin
							s_nxt.wr_ok = 1'b1;
						end
					end else if (i_rx_last) begin
						s_nxt.ec = EC_LEN;
						s_nxt.st = S_DRAIN;
					end
				end
			end
			S_XFER: begin
				mem_we = 1'b1;
				mem_wa = {s_r.dst_r, xd[MAW-1:0]};
				mem_wd = mem_q[{s_r.src_r, xs[MAW-1:0]}];
				if (s_r.dst_r == REGION_PV) begin
					s_nxt.cflag[xd[MAW-1:0]] = 1'b0;
				end
				s_nxt.idx = s_r.idx + 15'h0001;
				if (s_r.idx == s_r.cnt - 15'h0001) begin
					s_nxt.st = S_DRAIN;
				end
			end
			S_WDATA: begin
				if (s_r.saw_last) begin
					if (s_r.wr_ok && s_r.is_rt) begin
						s_nxt.stg_ok = s_r.fmt_ok;
						if (!s_r.fmt_ok) begin
							s_nxt.ec = EC_FMT;
						end
					end
					s_nxt.st = S_RESP;
					s_nxt.idx = '0;
				end else if (take) begin
					s_nxt.saw_last = i_rx_last;
					if (!s_r.have_hi) begin
						s_nxt.hi = v;
						s_nxt.have_hi = 1'b1;
					end else begin
						s_nxt.have_hi = 1'b0;
						if (s_r.wr_ok && s_r.idx < s_r.cnt) begin
							prm_we = 1'b1;
							prm_wa = {s_r.parea, PAW'(s_r.pbeg + {1'b0, s_r.idx})};
							prm_wd = {s_r.hi, v};
							s_nxt.idx = s_r.idx + 15'h0001;
						end
					end
					// routing format check, byte by byte
					if (s_r.rb == 7'h00) begin
						s_nxt.lcnt = v;
						bad = v > LNT_MAX;
					end else if (s_r.rb == 7'h01) begin
						bad = v != 8'h00;
					end else if (s_r.rb < LNT_BYTES) begin
						if ({1'b0, eb[6:1]} < s_r.lcnt) begin
							bad = s_r.rb[0] ? (v < UNIT_MIN || v > UNIT_MAX)
								: (v == 8'h00 || v > NET_MAX);
						end
					end else if (s_r.rb == LNT_BYTES) begin
						s_nxt.rcnt = v;
						bad = v > RNT_MAX;
					end else if ({3'b000, s_r.rk} < s_r.rcnt) begin
						case (s_r.rj)
							2'h0: bad = v == 8'h00 || v > DST_MAX;
							2'h1: bad = v == 8'h00 || v > NET_MAX;
							default: bad = v == 8'h00 || v > NODE_MAX;
						endcase
						s_nxt.rj = (s_r.rj == 2'h2) ? 2'h0 : s_r.rj + 2'h1;
						s_nxt.rk = (s_r.rj == 2'h2) ? s_r.rk + 5'h01 : s_r.rk;
					end
					if (s_r.is_rt && s_r.wr_ok && bad) begin
						s_nxt.fmt_ok = 1'b0;
					end
					if (s_r.rb != 7'h7f) begin
						s_nxt.rb = s_r.rb + 7'h01;
					end
				end
			end
			S_DRAIN: begin
				if (s_r.saw_last) begin
					s_nxt.st = S_RESP;
					s_nxt.idx = '0;
				end else if (take) begin
					s_nxt.saw_last = i_rx_last;
				end
			end
			S_RESP: begin
				ser.valid = 1'b1;
				case (s_r.idx)
					15'h0000: ser.word = s_r.cmd;
					15'h0001: ser.word = s_r.ec;
					15'h0002: ser.word = s_r.pcode;
					15'h0003: ser.word = s_r.pbeg;
					15'h0004: ser.word = {s_r.lastf, s_r.cnt};
					default: ser.word = prm_q[{s_r.parea, roff[PAW-1:0]}];
				endcase
				ser.last = ({1'b0, s_r.idx} == rlen - 16'h0001);
				if (ser.ready) begin
					s_nxt.idx = s_r.idx + 15'h0001;
					if (ser.last) begin
						s_nxt.st = S_HDR;
						s_nxt.hcnt = '0;
						s_nxt.saw_last = 1'b0;
						s_nxt.last_ec = s_r.ec;
						s_nxt.ec = EC_OK;
						s_nxt.cmd = '0;
					end
				end
			end
			S_LOAD: begin
				// a table that failed its check never replaces the one in use
				rt_we = s_r.stg_ok;
				rt_wa = s_r.idx[5:0];
				rt_wd = prm_q[{PA_RT, PAW'(s_r.idx)}];
				s_nxt.idx = s_r.idx + 15'h0001;
				if (!s_r.stg_ok || s_r.idx == 15'(RT_WORDS - 16'h0001)) begin
					s_nxt.act_ok = s_r.act_ok || s_r.stg_ok;
					s_nxt.rst_pend = 1'b0;
					s_nxt.st = S_HDR;
				end
			end
			default: s_nxt.st = S_HDR;
		endcase

		// ======================================================
		// register port; software sets come last so they win over clears
		if (i_reg_wr) begin
			case (i_reg_addr)
				REG_CTRL: begin
					s_nxt.mode = i_reg_wdata[CTRL_MODE_LSB +: 3];
					s_nxt.key = i_reg_wdata[CTRL_KEY_BIT];
					s_nxt.foreign = i_reg_wdata[CTRL_FOREIGN_BIT];
					s_nxt.bank = i_reg_wdata[CTRL_BANK_LSB +: 3];
				end
				REG_RESTART: begin
					if (i_reg_wdata[0]) begin
						s_nxt.rst_pend = 1'b1;
					end
				end
				REG_ADDR: s_nxt.addr = i_reg_wdata[21:0];
				REG_DATA: begin
					// engine writes have the port; a colliding software write is dropped
					case (s_r.addr[ADDR_SPACE_LSB +: 2])
						SP_MEM: begin
							if (!mem_we && s_r.addr[ADDR_REGION_LSB +: 4] < 4'(MEM_REGIONS)) begin
								mem_we = 1'b1;
								mem_wa = {s_r.addr[ADDR_REGION_LSB +: 4], s_r.addr[MAW-1:0]};
								mem_wd = i_reg_wdata[15:0];
							end
						end
						SP_PRM: begin
							if (!prm_we && s_r.addr[ADDR_REGION_LSB +: 3] < PA_NUM) begin
								prm_we = 1'b1;
								prm_wa = {s_r.addr[ADDR_REGION_LSB +: 3], s_r.addr[PAW-1:0]};
								prm_wd = i_reg_wdata[15:0];
							end
						end
						SP_FLAG: begin
							if (i_reg_wdata[0]) begin
								s_nxt.cflag[s_r.addr[MAW-1:0]] = 1'b1;
							end
						end
						default: ;
					endcase
				end
				default: ;
			endcase
		end
		s_nxt.rdata = '0;
		if (i_reg_rd) begin
			case (i_reg_addr)
				REG_CTRL: s_nxt.rdata = {21'h0, s_r.bank, 2'h0, s_r.foreign, s_r.key, 1'b0, s_r.mode};
				REG_STATUS: s_nxt.rdata = {13'h0, s_r.act_ok, s_r.stg_ok,
						(s_r.st != S_HDR || s_r.hcnt != 4'h0), s_r.last_ec};
				REG_ADDR: s_nxt.rdata = {10'h0, s_r.addr};
				REG_DATA: begin
					case (s_r.addr[ADDR_SPACE_LSB +: 2])
						SP_MEM: if (s_r.addr[ADDR_REGION_LSB +: 4] < 4'(MEM_REGIONS)) begin
							s_nxt.rdata = {16'h0,
								mem_q[{s_r.addr[ADDR_REGION_LSB +: 4], s_r.addr[MAW-1:0]}]};
						end
						SP_PRM: if (s_r.addr[ADDR_REGION_LSB +: 3] < PA_NUM) begin
							s_nxt.rdata = {16'h0,
								prm_q[{s_r.addr[ADDR_REGION_LSB +: 3], s_r.addr[PAW-1:0]}]};
						end
						SP_RTACT: if (s_r.addr[15:0] < RT_WORDS) begin
							s_nxt.rdata = {16'h0, rt_act[s_r.addr[5:0]]};
						end
						default: s_nxt.rdata = {31'h0, s_r.cflag[s_r.addr[MAW-1:0]]};
					endcase
				end
				default: ;
			endcase
		end
		// held low until the serialiser has sent the last reply byte
		s_nxt.rx_rdy = !o_tx_valid && !ser.valid
			&& ((s_nxt.st == S_HDR && !(s_nxt.rst_pend && s_nxt.hcnt == 4'h0))
			|| ((s_nxt.st == S_WDATA || s_nxt.st == S_DRAIN) && !s_nxt.saw_last));
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_r <= '0;
			s_r.st <= S_HDR;
			s_r.ec <= EC_RST;
			s_r.last_ec <= EC_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	pmh_ser u_ser (
		.i_core_clk(i_core_clk),
		.i_resetn(i_resetn),
		.w(ser.snk),
		.i_tx_ready(i_tx_ready),
		.o_tx_valid(o_tx_valid),
		.o_tx_byte(o_tx_byte),
		.o_tx_last(o_tx_last)
	);

	assign o_rx_ready = s_r.rx_rdy;
	assign o_reg_rdata = s_r.rdata;
endmodule // pmh_top

// ---- tb.sv ----
// tb: command and register scenarios for pmh_top
// assumes: pmh_host drives the command link, tb drives the register port
`timescale 1ns/1ns
module tb
	import pmh_pkg::*;
;
	logic clk, rstn, rxv, rxl, rxr, txr, txv, txl, wr_s, rd_s;
	logic [7:0] rxb, txb, ra;
	logic [31:0] wd, rdd, v;
	logic [7:0] fr[$];
	int err_count = 0;
	int compares = 0;
	pmh_top uut (.i_core_clk(clk), .i_resetn(rstn), .i_rx_valid(rxv), .i_rx_byte(rxb),
		.i_rx_last(rxl), .o_rx_ready(rxr), .i_tx_ready(txr), .o_tx_valid(txv),
		.o_tx_byte(txb), .o_tx_last(txl), .i_reg_addr(ra), .i_reg_wdata(wd),
		.i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdd));
	pmh_host host (.i_core_clk(clk), .o_rx_valid(rxv), .o_rx_byte(rxb), .o_rx_last(rxl),
		.i_rx_ready(rxr), .o_tx_ready(txr), .i_tx_valid(txv), .i_tx_byte(txb),
		.i_tx_last(txl));
	// ==========
	// tasks
	task automatic end_of_test();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr_s <= 1'b1;
		ra <= a;
		wd <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		rd_s <= 1'b1;
		ra <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		v = rdd;
	endtask
	task automatic peek(input logic [1:0] s, input logic [3:0] g, input logic [15:0] w,
		input logic [15:0] e);
		wr(REG_ADDR, {10'h0, s, g, w});
		rd(REG_DATA);
		chk(v, {16'h0, e});
	endtask
	task automatic poke(input logic [1:0] s, input logic [3:0] g, input logic [15:0] w,
		input logic [15:0] d);
		wr(REG_ADDR, {10'h0, s, g, w});
		wr(REG_DATA, {16'h0, d});
	endtask
	task automatic st(input logic [1:0] e);
		rd(REG_STATUS);
		chk({30'h0, v[18:17]}, {30'h0, e});
	endtask
	task automatic prm(input logic [15:0] c, a, b, n);
		fr = {c[15:8], c[7:0], a[15:8], a[7:0], b[15:8], b[7:0], n[15:8], n[7:0]};
	endtask
	task automatic dw(input logic [15:0] w);
		fr.push_back(w[15:8]);
		fr.push_back(w[7:0]);
	endtask
	task automatic xf(input logic [7:0] sa, input logic [15:0] sw, input logic [7:0] da,
		input logic [15:0] dst, input logic [15:0] n);
		fr = {8'h01, 8'h05, sa, sw[15:8], sw[7:0], 8'h00, da, dst[15:8], dst[7:0], 8'h00,
			n[15:8], n[7:0]};
	endtask
	task automatic run(input logic [15:0] c, input logic [15:0] ec);
		int n;
		host.send(fr);
		n = 0;
		while (!host.done && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 2000 || host.hang != 0) begin
			err_count++;
			end_of_test();
		end
		chk({host.reply[0], host.reply[1], host.reply[2], host.reply[3]}, {c, ec});
	endtask
	task automatic rb(input int i, input logic [15:0] w);
		chk({16'h0, host.reply[i], host.reply[i + 1]}, {16'h0, w});
	endtask
	task automatic rt(input logic [15:0] w0, input logic [15:0] ec);
		prm(CMD_PWR, PA_BASE + 16'h2, 16'h0, 16'h0012);
		dw(w0);
		dw(16'h0110);
		repeat (15) dw(16'h0);
		dw(16'h0000);
		run(CMD_PWR, ec);
	endtask
	// ==========
	// clock, reset and scenarios
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		{rstn, wr_s, rd_s, ra, wd} = '0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(REG_CTRL);
		chk(v, 32'h0);
		rd(8'h14);
		chk(v, 32'h0);
		$display("test reset done");
		prm(CMD_PWR, PA_BASE, 16'h0, 16'h0002);
		dw(16'h1234);
		dw(16'habcd);
		run(CMD_PWR, EC_OK);
		peek(SP_PRM, 4'h0, 16'h0, 16'h1234);
		prm(CMD_PWR, PA_BASE, 16'h01fe, 16'h8002);
		dw(16'h3c3c);
		dw(16'h0f0f);
		run(CMD_PWR, EC_OK);
		prm(CMD_PWR, PA_BASE, 16'h01ff, 16'h0001);
		dw(16'h5a5a);
		run(CMD_PWR, EC_NOLAST);
		prm(CMD_PWR, PA_BASE, 16'h0, 16'h0);
		run(CMD_PWR, EC_OK);
		peek(SP_PRM, 4'h0, 16'h01ff, 16'h0f0f);
		peek(SP_PRM, 4'h0, 16'h0, 16'h1234);
		$display("test param write done");
		host.slow <= 1'b1;
		prm(CMD_PRD, PA_BASE, 16'h01fe, 16'h0002);
		run(CMD_PRD, EC_OK);
		rb(8, 16'h8002);
		rb(10, 16'h3c3c);
		rb(12, 16'h0f0f);
		prm(CMD_PRD, PA_BASE, 16'h0, 16'h0002);
		run(CMD_PRD, EC_OK);
		rb(8, 16'h0002);
		rb(10, 16'h1234);
		host.slow <= 1'b0;
		prm(CMD_PRD, PA_BASE, 16'h0, 16'h010b);
		run(CMD_PRD, EC_RANGE);
		prm(CMD_PRD, PA_BASE, 16'h0, 16'h8001);
		run(CMD_PRD, EC_RANGE);
		prm(CMD_PRD, PA_BASE + 16'h2, 16'h0030, 16'h0001);
		run(CMD_PRD, EC_RANGE);
		prm(CMD_PWR, PA_BASE, 16'h0200, 16'h0001);
		dw(16'h0);
		run(CMD_PWR, EC_RANGE);
		prm(CMD_PRD, PA_BASE + 16'h5, 16'h0, 16'h0001);
		run(CMD_PRD, EC_AREA);
		$display("test param read done");
		wr(REG_CTRL, 32'h20);
		prm(CMD_PWR, PA_BASE, 16'h0, 16'h0001);
		dw(16'hdead);
		run(CMD_PWR, EC_ACCESS);
		wr(REG_CTRL, 32'h10);
		run(CMD_PWR, EC_PROT);
		peek(SP_PRM, 4'h0, 16'h0, 16'h1234);
		wr(REG_CTRL, 32'h2);
		prm(CMD_PWR, PA_BASE + 16'h1, 16'h0, 16'h0001);
		dw(16'hbeef);
		run(CMD_PWR, EC_MODE);
		wr(REG_CTRL, 32'h0);
		run(CMD_PWR, EC_OK);
		peek(SP_PRM, 4'h1, 16'h0, 16'hbeef);
		$display("test protection done");
		rt(16'h0100, EC_OK);
		st(2'b01);
		wr(REG_RESTART, 32'h1);
		repeat (50) @(posedge clk);
		st(2'b11);
		peek(SP_RTACT, 4'h0, 16'h1, 16'h0110);
		rt(16'h0101, EC_FMT);
		st(2'b10);
		peek(SP_RTACT, 4'h0, 16'h0, 16'h0100);
		$display("test routing done");
		poke(SP_MEM, 4'h2, 16'h0, 16'h1111);
		poke(SP_MEM, 4'h2, 16'h1, 16'h2222);
		poke(SP_FLAG, 4'h1, 16'h0010, 16'h0001);
		peek(SP_FLAG, 4'h1, 16'h0010, 16'h0001);
		wr(REG_CTRL, 32'h304);
		xf(MA_DM, 16'h0, MA_PV, 16'h0010, 16'h0002);
		run(CMD_XFER, EC_OK);
		peek(SP_MEM, 4'h1, 16'h0011, 16'h2222);
		peek(SP_FLAG, 4'h1, 16'h0010, 16'h0000);
		xf(MA_DM, 16'h0, MA_EMC, 16'h0005, 16'h0001);
		run(CMD_XFER, EC_OK);
		peek(SP_MEM, 4'h6, 16'h0005, 16'h1111);
		xf(MA_DM, 16'h1, MA_EM0 + 8'h3, 16'h0006, 16'h0001);
		run(CMD_XFER, EC_OK);
		peek(SP_MEM, 4'h6, 16'h0006, 16'h2222);
		xf(MA_DM, 16'h00ff, MA_CIO, 16'h0, 16'h0002);
		run(CMD_XFER, EC_RANGE);
		prm(16'h0909, PA_BASE, 16'h0, 16'h0001);
		run(16'h0909, EC_CMD);
		$display("test transfer done");
		end_of_test();
	end
endmodule // tb
bind pmh_top pmh_props props (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
	.i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte), .i_rx_last(i_rx_last),
	.o_rx_ready(o_rx_ready), .i_tx_ready(i_tx_ready), .o_tx_valid(o_tx_valid),
	.o_tx_byte(o_tx_byte), .o_tx_last(o_tx_last), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata));
